// >>> hdl/pio_sync.sv
`timescale 1ns/10ps
`default_nettype none
// three-stage pin synchroniser; output moves only when stages 2 and 3 agree
module pio_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             mclk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            stage1 <= '1;
            stage2 <= '1;
            stage3 <= '1;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // undriven pins are pulled up, so idle level is one
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            level_out <= '1;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level_out[i] <= stage3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/pio_top.sv
// Contract
// - bit 7 high: setup byte sets A, B, C-high, C-low directions, 1 = input
// - after reset every port and both C halves are inputs
// - setup byte with bit 7 low addresses one port C line by bits 3..1
// - bit 0 of that byte is the new line level; other C lines kept
// - interrupt allow bit gates requests and resets to zero
// - two-bit trigger field: low, high, falling, rising on codes 00..11
// - reading the status register returns pending and clears it
// - pending reads as one at bits 0 and 4, zero otherwise
// - interrupt condition watches port A line 0 only
// - output registers take writes in any direction and keep them
// - split port C reads pins for input half, driven value for output half
`timescale 1ns/10ps
`default_nettype none
module pio_top (
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic [2:0] addr_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] rdata_out,
    input  wire logic [7:0] port_a_in,
    output logic      [7:0] port_a_out,
    output logic      [7:0] port_a_oe_out,
    input  wire logic [7:0] port_b_in,
    output logic      [7:0] port_b_out,
    output logic      [7:0] port_b_oe_out,
    input  wire logic [7:0] port_c_in,
    output logic      [7:0] port_c_out,
    output logic      [7:0] port_c_oe_out,
    output logic            irq_out
);
    logic [7:0] pin_a;
    logic [7:0] pin_b;
    logic [7:0] pin_c;
    logic       dir_a_sel;
    logic       dir_b_sel;
    logic       dir_c_low_sel;
    logic       dir_c_high_sel;
    logic       irq_allow;
    logic [1:0] trigger_type;
    logic       pending;
    logic       src_prev;
    logic       trig_event;
    logic       status_read;
    logic       wr_setup;
    logic [7:0] next_rdata;

    pio_sync #(.WIDTH(8)) u_sync_a (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .pin_in    (port_a_in),
        .level_out (pin_a)
    );

    pio_sync #(.WIDTH(8)) u_sync_b (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .pin_in    (port_b_in),
        .level_out (pin_b)
    );

    pio_sync #(.WIDTH(8)) u_sync_c (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .pin_in    (port_c_in),
        .level_out (pin_c)
    );

    // input pins where the direction is input, else the driven value
    function automatic logic [7:0] merge_read(
        input logic [7:0] pins,
        input logic [7:0] driven,
        input logic [7:0] in_mask
    );
        merge_read = (pins & in_mask) | (driven & ~in_mask);
    endfunction

    assign wr_setup    = wr_in && (addr_in == pio_pkg::OFS_SETUP);
    assign status_read = rd_in && (addr_in == pio_pkg::OFS_IRQ_STS);

    // direction selections, all input from reset
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            dir_a_sel      <= pio_pkg::DIR_RESET;
            dir_b_sel      <= pio_pkg::DIR_RESET;
            dir_c_low_sel  <= pio_pkg::DIR_RESET;
            dir_c_high_sel <= pio_pkg::DIR_RESET;
            port_a_oe_out  <= '0;
            port_b_oe_out  <= '0;
            port_c_oe_out  <= '0;
        end else if (wr_setup && wdata_in[pio_pkg::CMD_KIND_BIT]) begin
            // bits 2, 5 and 6 play no part
            dir_a_sel      <= wdata_in[pio_pkg::DIR_A_BIT];
            dir_b_sel      <= wdata_in[pio_pkg::DIR_B_BIT];
            dir_c_low_sel  <= wdata_in[pio_pkg::DIR_C_LOW_BIT];
            dir_c_high_sel <= wdata_in[pio_pkg::DIR_C_HIGH_BIT];
            port_a_oe_out  <= {8{~wdata_in[pio_pkg::DIR_A_BIT]}};
            port_b_oe_out  <= {8{~wdata_in[pio_pkg::DIR_B_BIT]}};
            port_c_oe_out  <= {{4{~wdata_in[pio_pkg::DIR_C_HIGH_BIT]}},
                               {4{~wdata_in[pio_pkg::DIR_C_LOW_BIT]}}};
        end
    end

    // output registers for A and B take writes regardless of direction
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            port_a_out <= pio_pkg::OUT_RESET;
            port_b_out <= pio_pkg::OUT_RESET;
        end else if (wr_in) begin
            if (addr_in == pio_pkg::OFS_PORT_A) begin
                port_a_out <= wdata_in;
            end
            if (addr_in == pio_pkg::OFS_PORT_B) begin
                port_b_out <= wdata_in;
            end
        end
    end

    // port C: whole-byte write or single-line command
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            port_c_out <= pio_pkg::OUT_RESET;
        end else if (wr_in && addr_in == pio_pkg::OFS_PORT_C) begin
            // both halves stored even when one is input
            port_c_out <= wdata_in;
        end else if (wr_setup && !wdata_in[pio_pkg::CMD_KIND_BIT]) begin
            port_c_out[wdata_in[pio_pkg::LINE_IDX_MSB:pio_pkg::LINE_IDX_LSB]]
                <= wdata_in[pio_pkg::LINE_LEVEL_BIT];
        end
    end

    // interrupt configuration
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_allow    <= pio_pkg::ALLOW_RESET;
            trigger_type <= pio_pkg::PIO_TRIG_LOW;
        end else if (wr_in && addr_in == pio_pkg::OFS_IRQ_CFG) begin
            irq_allow    <= wdata_in[pio_pkg::IRQ_ALLOW_BIT];
            trigger_type <= {wdata_in[pio_pkg::TRIG_HI_BIT],
                             wdata_in[pio_pkg::TRIG_LO_BIT]};
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            src_prev <= 1'b1;
        end else begin
            src_prev <= pin_a[pio_pkg::IRQ_SRC_BIT];
        end
    end

    always_comb begin
        case (pio_pkg::pio_trig_e'(trigger_type))
            pio_pkg::PIO_TRIG_LOW:
                trig_event = !pin_a[pio_pkg::IRQ_SRC_BIT];
            pio_pkg::PIO_TRIG_HIGH:
                trig_event = pin_a[pio_pkg::IRQ_SRC_BIT];
            pio_pkg::PIO_TRIG_FALL:
                trig_event = src_prev && !pin_a[pio_pkg::IRQ_SRC_BIT];
            pio_pkg::PIO_TRIG_RISE:
                trig_event = !src_prev && pin_a[pio_pkg::IRQ_SRC_BIT];
            default:
                trig_event = 1'b0;
        endcase
    end

    // a held level keeps pending set through a clearing read;
    // a new event in the read cycle wins over the clear
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pending <= 1'b0;
        end else begin
            pending <= trig_event || (pending && !status_read);
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= pending && irq_allow;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        case (addr_in)
            pio_pkg::OFS_PORT_A:
                next_rdata = merge_read(pin_a, port_a_out, {8{dir_a_sel}});
            pio_pkg::OFS_PORT_B:
                next_rdata = merge_read(pin_b, port_b_out, {8{dir_b_sel}});
            pio_pkg::OFS_PORT_C:
                next_rdata = merge_read(pin_c, port_c_out,
                    {{4{dir_c_high_sel}}, {4{dir_c_low_sel}}});
            pio_pkg::OFS_IRQ_CFG: begin
                next_rdata[pio_pkg::IRQ_ALLOW_BIT] = irq_allow;
                next_rdata[pio_pkg::TRIG_HI_BIT]   = trigger_type[1];
                next_rdata[pio_pkg::TRIG_LO_BIT]   = trigger_type[0];
            end
            pio_pkg::OFS_IRQ_STS: begin
                next_rdata[pio_pkg::PEND_PRI_BIT] = pending;
                next_rdata[pio_pkg::PEND_SEC_BIT] = pending;
            end
            default:
                next_rdata = 8'h00;
        endcase
    end

    // read data held until the next read
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_out <= pio_pkg::RDATA_RESET;
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// >>> shared/pio_pkg.sv
`default_nettype none
package pio_pkg;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    // byte offsets from the board base
    localparam logic [2:0] OFS_PORT_A  = 3'h0;
    localparam logic [2:0] OFS_PORT_B  = 3'h1;
    localparam logic [2:0] OFS_PORT_C  = 3'h2;
    localparam logic [2:0] OFS_SETUP   = 3'h3;
    localparam logic [2:0] OFS_IRQ_CFG = 3'h4;
    localparam logic [2:0] OFS_IRQ_STS = 3'h5;

    // port_setup_command fields
    localparam int unsigned CMD_KIND_BIT   = 7;
    localparam int unsigned DIR_C_LOW_BIT  = 0;
    localparam int unsigned DIR_B_BIT      = 1;
    localparam int unsigned DIR_C_HIGH_BIT = 3;
    localparam int unsigned DIR_A_BIT      = 4;
    localparam int unsigned LINE_LEVEL_BIT = 0;
    localparam int unsigned LINE_IDX_LSB   = 1;
    localparam int unsigned LINE_IDX_MSB   = 3;

    // irq_configuration fields
    localparam int unsigned TRIG_LO_BIT  = 0;
    localparam int unsigned TRIG_HI_BIT  = 1;
    localparam int unsigned IRQ_ALLOW_BIT = 2;

    // irq_pending_status fields
    localparam int unsigned PEND_PRI_BIT = 0;
    localparam int unsigned PEND_SEC_BIT = 4;

    // interrupt source line on port A
    localparam int unsigned IRQ_SRC_BIT = 0;

    // reset values
    localparam logic       DIR_RESET       = 1'b1;
    localparam logic [7:0] OUT_RESET       = 8'h00;
    localparam logic       ALLOW_RESET     = 1'b0;
    localparam logic [7:0] RDATA_RESET     = 8'h00;

    typedef enum logic [1:0] {
        PIO_TRIG_LOW  = 2'b00,
        PIO_TRIG_HIGH = 2'b01,
        PIO_TRIG_FALL = 2'b10,
        PIO_TRIG_RISE = 2'b11
    } pio_trig_e;
endpackage
`default_nettype wire

// >>> testbench/pio_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module pio_pin_model (
    input  wire logic [23:0] drive_in,
    input  wire logic [23:0] oe_in,
    input  wire logic [23:0] ext_in,
    output logic      [23:0] pin_out
);
    // undriven lines follow the field side, which idles at the pull-up level
    assign pin_out = (oe_in & drive_in) | (~oe_in & ext_in);
endmodule
`default_nettype wire

// >>> testbench/pio_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pio_top_checker (
    input wire logic       mclk_in,
    input wire logic       reset_in,
    input wire logic [2:0] addr_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] rdata_out,
    input wire logic [7:0] port_a_oe_out,
    input wire logic [7:0] port_b_out,
    input wire logic [7:0] port_b_oe_out,
    input wire logic [7:0] port_c_out,
    input wire logic [7:0] port_c_oe_out,
    input wire logic       irq_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    wire logic setup_wr = wr_in && addr_in == 3'h3;
    wire logic cfg_wr   = wr_in && addr_in == 3'h4;
    // allow cleared, then left alone long enough to reach the pin
    sequence allow_off_s;
        cfg_wr && !wdata_in[2] ##1 !cfg_wr [*3];
    endsequence
    dir_a_apply_a: assert property (setup_wr && wdata_in[7] |=>
        port_a_oe_out == {8{~$past(wdata_in[4])}}) else $error("dir a");
    dir_c_apply_a: assert property (setup_wr && wdata_in[7] |=>
        port_c_oe_out == {{4{~$past(wdata_in[3])}},
                          {4{~$past(wdata_in[0])}}})
        else $error("dir c");
    dir_hold_a: assert property (!setup_wr |=> $stable(port_b_oe_out))
        else $error("dir moved");
    reset_input_a: assert property ($past(reset_in) |->
        port_a_oe_out == 8'h00 && port_c_oe_out == 8'h00) else $error("oe");
    line_level_a: assert property (setup_wr && !wdata_in[7] |=>
        port_c_out[$past(wdata_in[3:1])] == $past(wdata_in[0]))
        else $error("line level");
    allow_gate_a: assert property (allow_off_s |-> !irq_out)
        else $error("irq not gated");
    status_copy_a: assert property (rd_in && addr_in == 3'h5 |=>
        rdata_out[0] == rdata_out[4] && rdata_out[7:5] == 3'h0
        && rdata_out[3:1] == 3'h0) else $error("status bits");
    out_write_a: assert property (wr_in && addr_in == 3'h1 |=>
        port_b_out == $past(wdata_in)) else $error("out reg");
endmodule
bind pio_top pio_top_checker pio_top_checker_inst (.mclk_in(mclk_in),
    .reset_in(reset_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
    .wdata_in(wdata_in), .rdata_out(rdata_out),
    .port_a_oe_out(port_a_oe_out), .port_b_out(port_b_out),
    .port_b_oe_out(port_b_oe_out), .port_c_out(port_c_out),
    .port_c_oe_out(port_c_oe_out), .irq_out(irq_out));
`default_nettype wire

// >>> testbench/pio_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module pio_top_tb_top;
    logic       mclk_in  = 1'b0;
    logic       reset_in = 1'b1;
    logic [2:0] addr_in  = 3'h0;
    logic       wr_in    = 1'b0;
    logic       rd_in    = 1'b0;
    logic [7:0] wdata_in = 8'h00;
    logic [7:0] a_ext    = 8'hff;
    logic [7:0] c_ext    = 8'hff;
    logic [7:0] rdata_out, got, a_out, a_oe, b_out, b_oe, c_out, c_oe;
    logic [7:0] a_pin, b_pin, c_pin;
    logic       irq_out;
    int         error_cnt   = 0;
    int         comparisons = 0;
    initial begin
        forever #50 mclk_in = ~mclk_in;
    end
    pio_top pio_top_inst (.mclk_in(mclk_in), .reset_in(reset_in),
        .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
        .rdata_out(rdata_out), .port_a_in(a_pin), .port_a_out(a_out),
        .port_a_oe_out(a_oe), .port_b_in(b_pin), .port_b_out(b_out),
        .port_b_oe_out(b_oe), .port_c_in(c_pin), .port_c_out(c_out),
        .port_c_oe_out(c_oe), .irq_out(irq_out));
    pio_pin_model pio_pin_model_inst (.drive_in({a_out, b_out, c_out}),
        .oe_in({a_oe, b_oe, c_oe}), .ext_in({a_ext, 8'hff, c_ext}),
        .pin_out({a_pin, b_pin, c_pin}));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        got = rdata_out;
    endtask
    task automatic t_reset;
        chk(a_oe | b_oe | c_oe, 8'h00);
        rd(3'h4);
        chk(got, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
    endtask
    task automatic t_dir;
        logic [7:0] d;
        for (int i = 0; i < 16; i++) begin
            d = {3'h7, i[3], i[2], 1'b1, i[1], i[0]};
            wr(3'h3, d);
            chk(a_oe, {8{~d[4]}});
            chk(b_oe, {8{~d[1]}});
            chk(c_oe, {{4{~d[3]}}, {4{~d[0]}}});
        end
        rd(3'h3);
        chk(got, 8'h00);
        rd(3'h7);
        chk(got, 8'h00);
    endtask
    task automatic t_preset;
        wr(3'h0, 8'h3c);
        chk(a_out, 8'h3c);
        wr(3'h1, 8'ha5);
        chk(b_out, 8'ha5);
        chk(b_oe, 8'h00);
        wr(3'h3, 8'h80);
        rd(3'h1);
        chk(got, 8'ha5);
        rd(3'h0);
        chk(got, 8'h3c);
    endtask
    task automatic t_line;
        logic [7:0] e;
        wr(3'h2, 8'h00);
        e = 8'h00;
        for (int s = 1; s >= 0; s--) begin
            for (int i = 0; i < 8; i++) begin
                wr(3'h3, {4'h7, i[2:0], s[0]});
                e[i] = s[0];
                chk(c_out, e);
            end
        end
    endtask
    task automatic t_split;
        wr(3'h3, 8'h81);
        c_ext <= 8'h3c;
        wr(3'h2, 8'h5a);
        repeat (6) @(posedge mclk_in);
        rd(3'h2);
        chk(got, 8'h5c);
        chk(c_out, 8'h5a);
        chk(c_out & c_oe, 8'h50);
        c_ext <= 8'hff;
    endtask
    task automatic t_irq;
        logic [7:0] b;
        wr(3'h3, 8'h9b);
        for (int m = 0; m < 4; m++) begin
            // other port A lines sit opposite to line 0 and hold still while it toggles: they must not count
            b = m[0] ? 8'hfe : 8'h01;
            a_ext <= b;
            wr(3'h4, {6'h01, m[1:0]});
            repeat (8) @(posedge mclk_in);
            rd(3'h5);
            rd(3'h5);
            chk(got, 8'h00);
            a_ext <= b ^ 8'h01;
            repeat (8) @(posedge mclk_in);
            chk({7'h00, irq_out}, 8'h01);
            rd(3'h5);
            chk(got, 8'h11);
            repeat (2) @(posedge mclk_in);
            rd(3'h5);
            chk(got, m[1] ? 8'h00 : 8'h11);
        end
        wr(3'h4, 8'h01);
        repeat (8) @(posedge mclk_in);
        chk({7'h00, irq_out}, 8'h00);
        rd(3'h5);
        chk(got, 8'h11);
        rd(3'h4);
        chk(got, 8'h01);
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        error_cnt++;
        end_of_test;
    end
    initial begin
        repeat (4) @(posedge mclk_in);
        reset_in <= 1'b0;
        t_reset;
        t_dir;
        t_preset;
        t_line;
        t_split;
        t_irq;
        end_of_test;
    end
endmodule
`default_nettype wire
